//--- verilog/dpll_ref_qual_pkg.sv
// constants and carrier types for reference qualification and loop modes
`default_nettype none
package dpll_ref_qual_pkg;

  // sizes
  localparam int NUM_LOOPS = 3;
  localparam int NUM_REFS  = 8;
  localparam int REF_W     = 3;
  localparam int DEV_W     = 8;
  localparam int OFS_W     = 24;
  localparam int GST_CNT_W = 25;

  // monitor bit positions in fail and mask vectors
  localparam int MON_W   = 5;
  localparam int MON_CFM = 0;
  localparam int MON_SCM = 1;
  localparam int MON_PFM = 2;
  localparam int MON_LOS = 3;
  localparam int MON_GST = 4;

  // guard soak timing
  localparam longint CLK_HZ          = 125_000_000;
  localparam longint GST_DISQ_MS     = 50;
  localparam longint GST_DISQ_CYC    = (GST_DISQ_MS * CLK_HZ + 999) / 1000;
  localparam int     GST_REQUAL_MULT = 4;

  typedef enum logic [2:0] {
    MODE_FREERUN   = 3'h0,
    MODE_FORCED_HO = 3'h1,
    MODE_AUTO      = 3'h2,
    MODE_FORCED_REF = 3'h3,
    MODE_NCO       = 3'h4
  } mode_e;

  typedef enum logic [2:0] {
    ST_DISABLED = 3'h0,
    ST_FREERUN  = 3'h1,
    ST_ACQ      = 3'h2,
    ST_NORMAL   = 3'h3,
    ST_HOLDOVER = 3'h4,
    ST_NCO      = 3'h5
  } loop_state_e;

  // pull-in and hold-in range: 12, 52, 83, 130, 400 ppm or unlimited
  typedef enum logic [2:0] {
    RANGE_12    = 3'h0,
    RANGE_52    = 3'h1,
    RANGE_83    = 3'h2,
    RANGE_130   = 3'h3,
    RANGE_400   = 3'h4,
    RANGE_UNLIM = 3'h5
  } range_e;

  // bandwidth: 5.2, 14, 28, 56, 112, 224, 448, 896 Hz
  typedef logic [2:0] bw_t;

  // phase slope limiting: 61 us/s, 7.5 us/s, 885 ns/s, unlimited
  typedef enum logic [1:0] {
    PSL_61US   = 2'h0,
    PSL_7P5US  = 2'h1,
    PSL_885NS  = 2'h2,
    PSL_UNLIM  = 2'h3
  } psl_e;

  typedef struct packed {
    logic [DEV_W-1:0] cfm_dev;
    logic [DEV_W-1:0] rise_dev;
    logic [DEV_W-1:0] fall_dev;
  } ref_meas_s;

  typedef struct packed {
    logic [DEV_W-1:0] cfm_lim;
    logic [DEV_W-1:0] scm_lim;
  } ref_lim_s;

  // loop control register
  typedef struct packed {
    logic              enable;
    mode_e             mode;
    logic [REF_W-1:0]  force_ref;
    logic [NUM_REFS-1:0] ref_en;
    logic [MON_W-1:0]  sw_mask;
    logic [MON_W-1:0]  ho_mask;
    range_e            range;
    bw_t               bw;
    psl_e              phase_slope_limiting;
  } loop_cfg_s;

  localparam loop_cfg_s LOOP_CFG_RST = '{
    enable:    1'b1,
    mode:      MODE_AUTO,
    force_ref: 3'h0,
    ref_en:    8'hFF,
    sw_mask:   5'h00,
    ho_mask:   5'h00,
    range:     RANGE_UNLIM,
    bw:        3'h0,
    phase_slope_limiting:       PSL_UNLIM
  };

  typedef struct packed {
    loop_state_e       st;
    logic [REF_W-1:0]  sel;
    logic              lock;
    logic              holdover;
    logic              follow_ref;
    logic              use_estimate;
    logic              nco_active;
    range_e            range;
    bw_t               bw;
    psl_e              phase_slope_limiting;
    logic [OFS_W-1:0]  ofs;
  } loop_stat_s;

endpackage
`default_nettype wire

//--- verilog/pin_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_st_s;

  sync_st_s st_ff;
  sync_st_s nxt_st;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.meta   = pin_in;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_out = st_ff.stable;

endmodule
`default_nettype wire

//--- verilog/guard_soak_timer.sv
// guard soak timer for one reference
`timescale 1ns/1ps
`default_nettype none
module guard_soak_timer #(
  parameter logic [24:0] DISQ_CYC = 25'(dpll_ref_qual_pkg::GST_DISQ_CYC)
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // control and monitor
  input  wire logic enable,
  input  wire logic raw_fail,
  output logic      soak_fail
);

  localparam logic [24:0] REQUAL_CYC =
    25'(dpll_ref_qual_pkg::GST_REQUAL_MULT * DISQ_CYC);

  typedef struct packed {
    logic        failed;
    logic [24:0] cnt;
  } gst_st_s;

  gst_st_s st_ff;
  gst_st_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!enable) begin
      nxt_st = '0;
    end else if (!st_ff.failed) begin
      // failure must persist for the whole disqualify period
      if (!raw_fail) begin
        nxt_st.cnt = '0;
      end else if (st_ff.cnt >= DISQ_CYC - 25'h1) begin
        nxt_st.failed = 1'b1;
        nxt_st.cnt    = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt + 25'h1;
      end
    end else begin
      // requalify period runs from the moment the failure clears
      if (raw_fail) begin
        nxt_st.cnt = '0;
      end else if (st_ff.cnt >= REQUAL_CYC - 25'h1) begin
        nxt_st.failed = 1'b0;
        nxt_st.cnt    = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt + 25'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign soak_fail = st_ff.failed;

endmodule
`default_nettype wire

//--- verilog/dpll_ref_qual_mode_ctrl.sv
// reference qualification and mode control for three loops
`timescale 1ns/1ps
`default_nettype none
module dpll_ref_qual_mode_ctrl #(
  parameter logic [24:0] GST_DISQ_CYC =
    25'(dpll_ref_qual_pkg::GST_DISQ_CYC)
) (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // reference monitor measurements, same clock
  input  wire dpll_ref_qual_pkg::ref_meas_s [7:0] ref_meas,
  input  wire logic                   [7:0] ref_meas_vld,
  input  wire dpll_ref_qual_pkg::ref_lim_s  [7:0] ref_lim,
  input  wire logic                   [7:0] gst_en,
  // monitor pins from outside the clock domain
  input  wire logic                   [7:0] pfm_fail_pin,
  input  wire logic                   [7:0] los_pin,
  // loop control register writes
  input  wire logic                   [2:0] ctl_wr,
  input  wire dpll_ref_qual_pkg::loop_cfg_s [2:0] ctl_data,
  // oscillator frequency offset writes
  input  wire logic                   [2:0] ofs_wr,
  input  wire logic                   [23:0] ofs_data,
  // lock indicators from the loop cores
  input  wire logic                   [2:0] lock_ind,
  // loop status
  output dpll_ref_qual_pkg::loop_stat_s [2:0] loop_stat,
  output logic                        [7:0] ref_fail_qual
);

  localparam int NL = dpll_ref_qual_pkg::NUM_LOOPS;
  localparam int NR = dpll_ref_qual_pkg::NUM_REFS;
  localparam int MW = dpll_ref_qual_pkg::MON_W;

  typedef struct packed {
    dpll_ref_qual_pkg::loop_state_e st;
    logic [dpll_ref_qual_pkg::REF_W-1:0] sel;
    logic [dpll_ref_qual_pkg::OFS_W-1:0] ofs;
  } loop_reg_s;

  typedef struct packed {
    dpll_ref_qual_pkg::loop_cfg_s [NL-1:0] cfg;
    loop_reg_s                    [NL-1:0] lp;
  } ctrl_st_s;

  // highest-priority set bit: index 0 is the highest priority
  function automatic logic [3:0] pick_first(input logic [7:0] v);
    logic [3:0] res;
    res = 4'h0;
    for (int i = NR - 1; i >= 0; i--) begin
      if (v[i]) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  ctrl_st_s st_ff;
  ctrl_st_s nxt_st;

  logic [7:0]    pfm_s;
  logic [7:0]    los_s;
  logic [7:0]    cfm_fail;
  logic [7:0]    scm_fail;
  logic [7:0]    soak_fail;
  logic [MW-1:0] ref_fail [NR];

  // monitor pins pass two flip-flops first
  pin_sync #(
    .W (16)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin_in  ({los_pin, pfm_fail_pin}),
    .pin_out ({los_s, pfm_s})
  );

  // per-reference qualification
  genvar r;
  generate
    for (r = 0; r < NR; r++) begin : g_ref
      assign cfm_fail[r] = ref_meas_vld[r] &
        (ref_meas[r].cfm_dev > ref_lim[r].cfm_lim);
      assign scm_fail[r] = ref_meas_vld[r] &
        ((ref_meas[r].rise_dev > ref_lim[r].scm_lim) |
         (ref_meas[r].fall_dev > ref_lim[r].scm_lim));

      // only coarse and cycle failures drive the soak timer
      guard_soak_timer #(
        .DISQ_CYC (GST_DISQ_CYC)
      ) u_gst (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .enable    (gst_en[r]),
        .raw_fail  (cfm_fail[r] | scm_fail[r]),
        .soak_fail (soak_fail[r])
      );

      always_comb begin
        ref_fail[r]                             = '0;
        ref_fail[r][dpll_ref_qual_pkg::MON_CFM] = cfm_fail[r];
        ref_fail[r][dpll_ref_qual_pkg::MON_SCM] = scm_fail[r];
        ref_fail[r][dpll_ref_qual_pkg::MON_PFM] = pfm_s[r];
        ref_fail[r][dpll_ref_qual_pkg::MON_LOS] = los_s[r];
        ref_fail[r][dpll_ref_qual_pkg::MON_GST] = soak_fail[r];
      end

      assign ref_fail_qual[r] = soak_fail[r];
    end
  endgenerate

  // loop mode state machines
  always_comb begin
    dpll_ref_qual_pkg::loop_cfg_s c;
    loop_reg_s  cur;
    logic [7:0] sw_bad;
    logic [7:0] ho_bad;
    logic [7:0] usable;
    logic [3:0] best;
    logic [3:0] top;
    logic [3:0] tgt;
    logic       tgt_ok;
    c      = dpll_ref_qual_pkg::LOOP_CFG_RST;
    cur    = '0;
    sw_bad = '0;
    ho_bad = '0;
    usable = '0;
    best   = '0;
    top    = '0;
    tgt    = '0;
    tgt_ok = 1'b0;
    nxt_st = st_ff;
    for (int l = 0; l < NL; l++) begin
      c   = st_ff.cfg[l];
      cur = st_ff.lp[l];
      // masks decide which monitors count for switching and holdover
      for (int i = 0; i < NR; i++) begin
        sw_bad[i] = |(ref_fail[i] & c.sw_mask);
        ho_bad[i] = |(ref_fail[i] & c.ho_mask);
      end
      usable = c.ref_en & ~sw_bad & ~ho_bad;
      best   = pick_first(usable);
      top    = pick_first(c.ref_en);
      if (ctl_wr[l]) begin
        nxt_st.cfg[l] = ctl_data[l];
      end
      if (ofs_wr[l]) begin
        nxt_st.lp[l].ofs = ofs_data;
      end
      if (!c.enable) begin
        nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_DISABLED;
      end else begin
        unique case (c.mode)
          dpll_ref_qual_pkg::MODE_FREERUN: begin
            nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_FREERUN;
          end
          dpll_ref_qual_pkg::MODE_NCO: begin
            nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_NCO;
          end
          dpll_ref_qual_pkg::MODE_FORCED_HO: begin
            // keeps the last selected reference
            nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_HOLDOVER;
          end
          dpll_ref_qual_pkg::MODE_FORCED_REF: begin
            nxt_st.lp[l].sel = c.force_ref;
            if (ho_bad[c.force_ref]) begin
              nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_HOLDOVER;
            end else if (lock_ind[l] &&
                         (cur.st == dpll_ref_qual_pkg::ST_ACQ ||
                          cur.st == dpll_ref_qual_pkg::ST_NORMAL)) begin
              nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_NORMAL;
            end else begin
              nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_ACQ;
            end
          end
          dpll_ref_qual_pkg::MODE_AUTO: begin
            if (cur.st == dpll_ref_qual_pkg::ST_HOLDOVER ||
                cur.st == dpll_ref_qual_pkg::ST_DISABLED ||
                cur.st == dpll_ref_qual_pkg::ST_FREERUN ||
                cur.st == dpll_ref_qual_pkg::ST_NCO) begin
              // leave holdover only toward a clean reference
              tgt    = (c.sw_mask != '0) ? best : top;
              tgt_ok = tgt[3] & ~sw_bad[tgt[2:0]] &
                       ~ho_bad[tgt[2:0]];
              if (tgt_ok) begin
                nxt_st.lp[l].sel = tgt[2:0];
                nxt_st.lp[l].st  = dpll_ref_qual_pkg::ST_ACQ;
              end else begin
                nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_HOLDOVER;
              end
            end else if (ho_bad[cur.sel] || !c.ref_en[cur.sel]) begin
              // holdover takes precedence over a switch
              nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_HOLDOVER;
            end else if (sw_bad[cur.sel]) begin
              if (best[3]) begin
                nxt_st.lp[l].sel = best[2:0];
                nxt_st.lp[l].st  = dpll_ref_qual_pkg::ST_ACQ;
              end else begin
                nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_HOLDOVER;
              end
            end else if (lock_ind[l]) begin
              nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_NORMAL;
            end else begin
              // no lock indication: keep trying the same reference
              nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_ACQ;
            end
          end
          default: begin
            nxt_st.lp[l].st = dpll_ref_qual_pkg::ST_FREERUN;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int l = 0; l < NL; l++) begin
        st_ff.cfg[l]   <= dpll_ref_qual_pkg::LOOP_CFG_RST;
        st_ff.lp[l].st <= dpll_ref_qual_pkg::ST_ACQ;
        st_ff.lp[l].sel <= '0;
        st_ff.lp[l].ofs <= '0;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  // status from state flip-flops
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_stat
      assign loop_stat[g].st   = st_ff.lp[g].st;
      assign loop_stat[g].sel  = st_ff.lp[g].sel;
      assign loop_stat[g].lock =
        (st_ff.lp[g].st == dpll_ref_qual_pkg::ST_NORMAL);
      assign loop_stat[g].holdover =
        (st_ff.lp[g].st == dpll_ref_qual_pkg::ST_HOLDOVER);
      assign loop_stat[g].follow_ref =
        (st_ff.lp[g].st == dpll_ref_qual_pkg::ST_ACQ) ||
        (st_ff.lp[g].st == dpll_ref_qual_pkg::ST_NORMAL);
      assign loop_stat[g].use_estimate =
        (st_ff.lp[g].st == dpll_ref_qual_pkg::ST_HOLDOVER);
      assign loop_stat[g].nco_active =
        (st_ff.lp[g].st == dpll_ref_qual_pkg::ST_NCO);
      assign loop_stat[g].range = st_ff.cfg[g].range;
      assign loop_stat[g].bw    = st_ff.cfg[g].bw;
      assign loop_stat[g].phase_slope_limiting   = st_ff.cfg[g].phase_slope_limiting;
      assign loop_stat[g].ofs   = st_ff.lp[g].ofs;
    end
  endgenerate

endmodule
`default_nettype wire

//--- test/ref_src_model.sv
// behavioural model of the reference sources seen by the monitors
`timescale 1ns/1ps
`default_nettype none
module ref_src_model (
  // failure commands from the bench
  input  wire logic [7:0]                        cfm_bad,
  input  wire logic [7:0]                        scm_bad,
  input  wire logic [7:0]                        pfm_bad,
  input  wire logic [7:0]                        los_bad,
  input  wire logic [7:0]                        meas_ok,
  // monitor view of the sources
  output var  dpll_ref_qual_pkg::ref_meas_s [7:0] ref_meas,
  output logic [7:0]                             ref_meas_vld,
  output var  dpll_ref_qual_pkg::ref_lim_s [7:0]  ref_lim,
  output logic [7:0]                             pfm_fail_pin,
  output logic [7:0]                             los_pin
);
  // a value at the limit is still good, one above it fails
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ref_lim[i].cfm_lim = 8'h40;
      ref_lim[i].scm_lim = 8'h20;
      ref_meas[i].cfm_dev = 8'h40 + 8'(cfm_bad[i]);
      ref_meas[i].rise_dev = 8'h20 + 8'(scm_bad[i] & !i[0]);
      ref_meas[i].fall_dev = 8'h20 + 8'(scm_bad[i] & i[0]);
    end
  end
  // cycle results are valid only where the bench sets meas_ok
  assign ref_meas_vld = meas_ok;
  assign pfm_fail_pin = pfm_bad;
  assign los_pin      = los_bad;
endmodule
`default_nettype wire

//--- test/dpll_ref_qual_mode_ctrl_asserts.sv
// assertions on loop status and guard soak timer outputs
`timescale 1ns/1ps
`default_nettype none
module dpll_ref_qual_mode_ctrl_asserts #(
  parameter logic [24:0] GST_DISQ_CYC = 25'(dpll_ref_qual_pkg::GST_DISQ_CYC)
) (
  // clock and reset
  input wire logic                                sys_clk,
  input wire logic                                rst_b,
  // monitor side
  input wire dpll_ref_qual_pkg::ref_meas_s [7:0]  ref_meas,
  input wire logic [7:0]                          ref_meas_vld,
  input wire dpll_ref_qual_pkg::ref_lim_s [7:0]   ref_lim,
  input wire logic [7:0]                          gst_en,
  input wire logic [7:0]                          pfm_fail_pin,
  input wire logic [7:0]                          los_pin,
  // control
  input wire logic [2:0]                          ctl_wr,
  input wire dpll_ref_qual_pkg::loop_cfg_s [2:0]  ctl_data,
  input wire logic [2:0]                          ofs_wr,
  input wire logic [23:0]                         ofs_data,
  input wire logic [2:0]                          lock_ind,
  // status
  input wire dpll_ref_qual_pkg::loop_stat_s [2:0] loop_stat,
  input wire logic [7:0]                          ref_fail_qual
);
  logic        raw0;
  logic [26:0] hi_ff;
  logic [26:0] lo_ff;

  function automatic logic [2:0] fix_st(input dpll_ref_qual_pkg::loop_cfg_s c);
    if (!c.enable)
      return dpll_ref_qual_pkg::ST_DISABLED;
    case (c.mode)
      dpll_ref_qual_pkg::MODE_FREERUN:   return dpll_ref_qual_pkg::ST_FREERUN;
      dpll_ref_qual_pkg::MODE_FORCED_HO: return dpll_ref_qual_pkg::ST_HOLDOVER;
      dpll_ref_qual_pkg::MODE_NCO:       return dpll_ref_qual_pkg::ST_NCO;
      default:                           return dpll_ref_qual_pkg::ST_ACQ;
    endcase
  endfunction

  // consecutive cycles of raw failure and of clean input on reference 0
  assign raw0 = ref_meas_vld[0] && (ref_meas[0].cfm_dev > ref_lim[0].cfm_lim
    || ref_meas[0].rise_dev > ref_lim[0].scm_lim
    || ref_meas[0].fall_dev > ref_lim[0].scm_lim);
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !raw0 || !gst_en[0])
      hi_ff <= '0;
    else if (!hi_ff[26])
      hi_ff <= hi_ff + 27'h1;
    if (!rst_b || raw0)
      lo_ff <= '0;
    else if (!lo_ff[26])
      lo_ff <= lo_ff + 27'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  gst_disq_a:
    assert property ($rose(ref_fail_qual[0]) |-> hi_ff >= GST_DISQ_CYC)
    else $error("soak failure raised too early");
  gst_requal_a:
    assert property ($fell(ref_fail_qual[0]) && $past(gst_en[0])
      |-> lo_ff >= 4 * GST_DISQ_CYC)
    else $error("soak failure cleared too early");
  gst_off_a:
    assert property (!gst_en[0] |=> !ref_fail_qual[0])
    else $error("soak failure while timer off");
  reset_vals_a:
    assert property ($rose(rst_b) |-> loop_stat[0].phase_slope_limiting == 2'h3
      && loop_stat[0].st == dpll_ref_qual_pkg::ST_ACQ
      && loop_stat[0].sel == 3'h0)
    else $error("reset status wrong");
  cfg_load_a:
    assert property (ctl_wr[2] |=> loop_stat[2].phase_slope_limiting == $past(ctl_data[2].phase_slope_limiting)
      && loop_stat[2].range == $past(ctl_data[2].range)
      && loop_stat[2].bw == $past(ctl_data[2].bw))
    else $error("control fields not loaded");
  ofs_load_a:
    assert property (ofs_wr[0] |=> loop_stat[0].ofs == $past(ofs_data))
    else $error("offset not loaded");
  fixed_mode_a:
    assert property (ctl_wr[0]
      && fix_st(ctl_data[0]) != dpll_ref_qual_pkg::ST_ACQ
      ##1 !ctl_wr[0] |=> loop_stat[0].st == fix_st($past(ctl_data[0], 2)))
    else $error("fixed mode state wrong");
  free_hold_a:
    assert property (loop_stat[0].st == dpll_ref_qual_pkg::ST_FREERUN
      && !$past(ctl_wr[0])
      |=> loop_stat[0].st == dpll_ref_qual_pkg::ST_FREERUN)
    else $error("free-run left without write");
  stat_flags_a:
    assert property (loop_stat[1].lock == (loop_stat[1].st == 3'h3)
      && loop_stat[1].holdover == (loop_stat[1].st == 3'h4)
      && loop_stat[1].use_estimate == loop_stat[1].holdover
      && loop_stat[1].follow_ref == (loop_stat[1].st inside {3'h2, 3'h3})
      && loop_stat[1].nco_active == (loop_stat[1].st == 3'h5))
    else $error("status flags disagree with state");

  cover property ($rose(ref_fail_qual[0]));
  cover property ($fell(ref_fail_qual[0]));
  cover property (loop_stat[0].st == 3'h3 ##1 loop_stat[0].st == 3'h4);
endmodule

bind dpll_ref_qual_mode_ctrl dpll_ref_qual_mode_ctrl_asserts #(
  .GST_DISQ_CYC(GST_DISQ_CYC)
) u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .ref_meas(ref_meas),
  .ref_meas_vld(ref_meas_vld), .ref_lim(ref_lim), .gst_en(gst_en),
  .pfm_fail_pin(pfm_fail_pin), .los_pin(los_pin), .ctl_wr(ctl_wr),
  .ctl_data(ctl_data), .ofs_wr(ofs_wr), .ofs_data(ofs_data),
  .lock_ind(lock_ind), .loop_stat(loop_stat), .ref_fail_qual(ref_fail_qual)
);
`default_nettype wire

//--- test/dpll_ref_qual_mode_ctrl_tb_top.sv
// self-checking bench for reference qualification and loop mode control
`timescale 1ns/1ps
`default_nettype none
module dpll_ref_qual_mode_ctrl_tb_top;
  localparam logic [24:0] DISQ  = 25'h000000A;
  localparam int          LIMIT = 3000;
  localparam logic [2:0]  ACQ   = dpll_ref_qual_pkg::ST_ACQ;
  localparam logic [2:0]  NRM   = dpll_ref_qual_pkg::ST_NORMAL;
  localparam logic [2:0]  HLD   = dpll_ref_qual_pkg::ST_HOLDOVER;
  localparam logic [2:0]  AUTO  = dpll_ref_qual_pkg::MODE_AUTO;
  localparam logic [2:0]  FREF  = dpll_ref_qual_pkg::MODE_FORCED_REF;
  localparam logic [2:0]  FHO   = dpll_ref_qual_pkg::MODE_FORCED_HO;
  localparam logic [2:0]  MTAB [4] = '{3'h0, 3'h4, 3'h1, 3'h7};

  logic                               sys_clk;
  logic                               rst_b;
  logic [7:0]                         cfm_bad, scm_bad, pfm_bad, los_bad;
  logic [7:0]                         meas_ok, gst_en;
  dpll_ref_qual_pkg::ref_meas_s [7:0] ref_meas;
  dpll_ref_qual_pkg::ref_lim_s [7:0]  ref_lim;
  logic [7:0]                         ref_meas_vld, pfm_fail_pin, los_pin;
  logic [7:0]                         ref_fail_qual;
  logic [2:0]                         ctl_wr, ofs_wr, lock_ind;
  dpll_ref_qual_pkg::loop_cfg_s [2:0] ctl_data;
  logic [23:0]                        ofs_data;
  dpll_ref_qual_pkg::loop_stat_s [2:0] loop_stat;
  logic [31:0]                        seed;
  int                                 n_mismatch = 0;
  int                                 num_checks = 0;
  int                                 cyc = 0;

  ref_src_model ref_src_model_i (
    .cfm_bad(cfm_bad), .scm_bad(scm_bad), .pfm_bad(pfm_bad),
    .los_bad(los_bad), .meas_ok(meas_ok), .ref_meas(ref_meas),
    .ref_meas_vld(ref_meas_vld), .ref_lim(ref_lim),
    .pfm_fail_pin(pfm_fail_pin), .los_pin(los_pin)
  );
  dpll_ref_qual_mode_ctrl #(.GST_DISQ_CYC(DISQ)) dpll_ref_qual_mode_ctrl_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .ref_meas(ref_meas),
    .ref_meas_vld(ref_meas_vld), .ref_lim(ref_lim), .gst_en(gst_en),
    .pfm_fail_pin(pfm_fail_pin), .los_pin(los_pin), .ctl_wr(ctl_wr),
    .ctl_data(ctl_data), .ofs_wr(ofs_wr), .ofs_data(ofs_data),
    .lock_ind(lock_ind), .loop_stat(loop_stat), .ref_fail_qual(ref_fail_qual)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // masks never carry the soak bit alone
  function automatic dpll_ref_qual_pkg::loop_cfg_s mk(input logic [2:0] md,
    input logic [4:0] sw, input logic [4:0] ho);
    mk = dpll_ref_qual_pkg::LOOP_CFG_RST;
    mk.mode = dpll_ref_qual_pkg::mode_e'(md);
    mk.sw_mask = sw;
    mk.ho_mask = ho;
    mk.force_ref = 3'h2;
    mk.ref_en = 8'h07;
  endfunction
  function automatic logic [2:0] fx(input dpll_ref_qual_pkg::loop_cfg_s c);
    if (!c.enable)
      return dpll_ref_qual_pkg::ST_DISABLED;
    if (c.mode == FHO)
      return HLD;
    if (c.mode == dpll_ref_qual_pkg::MODE_NCO)
      return dpll_ref_qual_pkg::ST_NCO;
    return dpll_ref_qual_pkg::ST_FREERUN;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic cst(input int l, input logic [2:0] s, input logic [2:0] r);
    chk(loop_stat[l].st === s && loop_stat[l].sel === r, "loop state");
  endtask
  task automatic wr(input int l, input dpll_ref_qual_pkg::loop_cfg_s c);
    ctl_data[l] = c;
    ctl_wr[l] = 1'b1;
    step(1);
    ctl_wr[l] = 1'b0;
    step(1);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    dpll_ref_qual_pkg::loop_cfg_s c;
    int l;
    rst_b = 1'b0;
    {cfm_bad, scm_bad, pfm_bad, los_bad, gst_en} = '0;
    meas_ok = 8'hFF;
    {ctl_wr, ofs_wr, lock_ind} = '0;
    ctl_data = {3{dpll_ref_qual_pkg::LOOP_CFG_RST}};
    ofs_data = 24'h000000;
    seed = 32'h57C16D9D;
    step(10);
    rst_b = 1'b1;
    for (int i = 0; i < 3; i++) begin
      cst(i, ACQ, 3'h0);
      chk(loop_stat[i].phase_slope_limiting === 2'h3, "reset slope");
    end
    // lock with unlimited slope before tight slope codes
    lock_ind = 3'h7;
    step(1);
    for (int i = 0; i < 3; i++) cst(i, NRM, 3'h0);
    // bandwidth and slope changes made in holdover
    for (int k = 0; k < 24; k++) begin
      c = mk(FHO, 5'h00, 5'h00);
      c.phase_slope_limiting = dpll_ref_qual_pkg::psl_e'(k % 4); // fast-lock elsewhere
      c.range = dpll_ref_qual_pkg::range_e'(k % 6);
      c.bw = 3'(k % 8);
      wr(k % 3, c);
      chk(loop_stat[k % 3].phase_slope_limiting === c.phase_slope_limiting, "slope");
      chk(loop_stat[k % 3].range === c.range, "range");
      chk(loop_stat[k % 3].bw === c.bw, "bandwidth");
      cst(k % 3, HLD, 3'h0);
    end
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      ofs_data = seed[31:8];
      ofs_wr[k % 3] = 1'b1;
      step(1);
      ofs_wr[k % 3] = 1'b0;
      chk(loop_stat[k % 3].ofs === seed[31:8], "offset");
      cfm_bad = seed[7:0];
      lock_ind = seed[10:8];
      c = mk(MTAB[k % 4], seed[15:12] & 5'h0B, seed[19:16] & 5'h0B);
      c.enable = (k != 3);
      wr(k % 3, c);
      step(3);
      cst(k % 3, fx(c), 3'h0);
    end
    cfm_bad = 8'h00;
    lock_ind = 3'h7;
    wr(0, mk(AUTO, 5'h01, 5'h00));
    step(1);
    cst(0, NRM, 3'h0);
    cfm_bad = 8'h01;
    step(1);
    cst(0, ACQ, 3'h1);
    cfm_bad = 8'h07;
    step(1);
    chk(loop_stat[0].st === HLD, "all bad");
    cfm_bad = 8'h03;
    step(1);
    cst(0, ACQ, 3'h2);
    wr(0, mk(AUTO, 5'h01, 5'h01));
    cfm_bad = 8'h04;
    step(1);
    chk(loop_stat[0].st === HLD, "holdover first");
    step(1);
    cst(0, ACQ, 3'h0);
    wr(0, mk(AUTO, 5'h00, 5'h01));
    cfm_bad = 8'h01;
    step(5);
    chk(loop_stat[0].st === HLD, "held while top bad");
    cfm_bad = 8'h00;
    step(1);
    cst(0, ACQ, 3'h0);
    wr(0, mk(AUTO, 5'h00, 5'h00));
    cfm_bad = 8'h01;
    step(3);
    cst(0, NRM, 3'h0);
    cfm_bad = 8'h00;
    wr(0, mk(AUTO, 5'h08, 5'h04));
    los_bad = 8'h01;
    step(2);
    cst(0, NRM, 3'h0);
    step(1);
    cst(0, ACQ, 3'h1);
    pfm_bad = 8'h02;
    step(3);
    chk(loop_stat[0].st === HLD, "monitor holdover");
    {los_bad, pfm_bad} = '0;
    wr(1, mk(FREF, 5'h0B, 5'h00));
    cfm_bad = 8'h04;
    step(3);
    cst(1, NRM, 3'h2);
    wr(1, mk(FREF, 5'h0B, 5'h01));
    cst(1, HLD, 3'h2);
    cfm_bad = 8'h00;
    gst_en = 8'h01;
    // invalid cycle results and precise failures leave the timer alone
    meas_ok = 8'hFE;
    scm_bad = 8'h01;
    pfm_bad = 8'h01;
    step(DISQ + 3);
    chk(ref_fail_qual[0] === 1'b0, "soak without valid fail");
    meas_ok = 8'hFF;
    step(DISQ - 1);
    chk(ref_fail_qual[0] === 1'b0, "soak early");
    step(1);
    chk(ref_fail_qual[0] === 1'b1, "soak late");
    scm_bad = 8'h00;
    step(4 * DISQ - 1);
    chk(ref_fail_qual[0] === 1'b1, "requal early");
    step(1);
    chk(ref_fail_qual[0] === 1'b0, "requal late");
    close_out();
  end
endmodule
`default_nettype wire
